// file: logic/trl_defines.svh
/*
  Constants for the transceiver reset-level sequencer: timing counts,
  strap defaults and reset values of the configuration bits.
  Assumes a 50 MHz core clock.
*/
`ifndef TRL_DEFINES_SVH
`define TRL_DEFINES_SVH

`define TRL_CLK_MHZ          50
`define TRL_BOOT_DELAY_US    100
`define TRL_BOOT_CYCLES      (`TRL_BOOT_DELAY_US * `TRL_CLK_MHZ)
`define TRL_OTP_WORDS        4
`define TRL_OTP_AW           2
`define TRL_STRAP_DEFAULT    8'hFC
`define TRL_STRAP_FORBIDDEN  8'hFF
`define TRL_ROLE_REMOTE      1'b0
`define TRL_DETECT_PASSIVE   1'b0
`define TRL_CNT_W            16

`endif

// file: logic/trl_pkg.sv
/*
  Types for the transceiver reset-level sequencer.
  Assumes trl_defines.svh supplies the numeric constants.
*/
package trl_pkg;

  // One-hot main states
  typedef enum logic [6:0] {
    TRL_ST_COLD   = 7'h01,
    TRL_ST_OTP    = 7'h02,
    TRL_ST_INIT   = 7'h04,
    TRL_ST_IDLE   = 7'h08,
    TRL_ST_SEARCH = 7'h10,
    TRL_ST_LOWPWR = 7'h20,
    TRL_ST_TUNNEL = 7'h40
  } trl_state_t;

endpackage : trl_pkg

// file: logic/trl_sync.sv
/*
  Two-flop synchroniser for a single level from outside the clock domain.
  Assumes the input is a level, not a pulse shorter than two clocks.
*/
`timescale 1ns/1ps
module trl_sync (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic din,
  output logic      dout
);

  logic meta_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= 1'b0;
      dout    <= 1'b0;
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end

endmodule : trl_sync

// file: logic/trl_seq.sv
/*
  Reset-level sequencer: cold reset, OTP shadow load, warm restart,
  radio-idle entry and exit, link reset by command or channel loss.
  Assumes the configuration port logic hands over warm_restart and link
  restart as one-cycle pulses plus an end-of-transaction pulse, all on
  clock; the enable pin is asynchronous and is synchronised here.
*/
`timescale 1ns/1ps
`include "trl_defines.svh"
module trl_seq #(
  parameter int BOOT_CYCLES = `TRL_BOOT_CYCLES
) (
  input  wire logic                      clock,
  input  wire logic                      rst_b,
  input  wire logic                      supply_good,
  input  wire logic                      radio_enable_pin,
  input  wire logic                      warm_restart,
  input  wire logic                      cfg_xfer_done,
  input  wire logic                      link_restart,
  input  wire logic                      partner_found,
  input  wire logic                      tunnel_start,
  input  wire logic                      channel_lost,
  input  wire logic                      cfg_wr,
  input  wire logic                      cfg_role_in,
  input  wire logic                      cfg_detect_in,
  input  wire logic                      cfg_pullup_in,
  input  wire logic [`TRL_OTP_AW-1:0]    otp_rd_data_idx,
  input  wire logic [7:0]                otp_rd_data,
  output logic [`TRL_OTP_AW-1:0]         otp_addr_ff,
  output logic [7:0]                     strap_pull_ff,
  output logic                           io_out_en_b_ff,
  output logic                           enable_pullup_ff,
  output logic                           role_ff,
  output logic                           detect_ff,
  output logic                           link_up_ff,
  output logic                           link_down_event_ff,
  output logic                           link_reset_pending_ff,
  output logic                           radio_idle_state,
  output logic                           partner_search_state,
  output logic                           ready_ff,
  output logic [7:0]                     shadow_word_ff [`TRL_OTP_WORDS]
);

  // ************************************************************
  // Synchronised enable pin and state
  // ************************************************************
  logic                  en_sync;
  logic                  en_prev_ff;
  logic                  warm_armed_ff;
  logic [`TRL_CNT_W-1:0] boot_cnt_ff;
  trl_pkg::trl_state_t   state_ff;
  trl_pkg::trl_state_t   nxt_state;

  trl_sync u_en_sync (
    .clock (clock),
    .rst_b (rst_b),
    .din   (radio_enable_pin),
    .dout  (en_sync)
  );

  wire en_fall     = en_prev_ff & ~en_sync;
  wire power_lost  = ~supply_good;
  wire boot_done   = (boot_cnt_ff == BOOT_CYCLES[`TRL_CNT_W-1:0]);
  wire warm_fire   = warm_armed_ff & cfg_xfer_done;
  wire linked      = (state_ff == trl_pkg::TRL_ST_LOWPWR) |
                     (state_ff == trl_pkg::TRL_ST_TUNNEL);
  wire cmd_reset   = link_restart & linked;
  wire pend_reset  = link_reset_pending_ff & (state_ff == trl_pkg::TRL_ST_LOWPWR);
  wire loss_reset  = channel_lost & linked;
  wire link_reset  = cmd_reset | pend_reset | loss_reset;
  wire otp_last    = (otp_addr_ff == `TRL_OTP_AW'(`TRL_OTP_WORDS - 1));
  wire in_boot     = (state_ff == trl_pkg::TRL_ST_COLD) |
                     (state_ff == trl_pkg::TRL_ST_OTP) |
                     (state_ff == trl_pkg::TRL_ST_INIT);

  assign radio_idle_state     = (state_ff == trl_pkg::TRL_ST_IDLE);
  assign partner_search_state = (state_ff == trl_pkg::TRL_ST_SEARCH);

  // ************************************************************
  // Main state machine
  // ************************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      trl_pkg::TRL_ST_COLD: begin
        if (boot_done) nxt_state = trl_pkg::TRL_ST_OTP;
      end
      trl_pkg::TRL_ST_OTP: begin
        if (otp_last) nxt_state = trl_pkg::TRL_ST_INIT;
      end
      trl_pkg::TRL_ST_INIT:   nxt_state = trl_pkg::TRL_ST_IDLE;
      trl_pkg::TRL_ST_IDLE: begin
        if (en_sync) nxt_state = trl_pkg::TRL_ST_SEARCH;
      end
      trl_pkg::TRL_ST_SEARCH: begin
        if (partner_found) nxt_state = trl_pkg::TRL_ST_LOWPWR;
      end
      trl_pkg::TRL_ST_LOWPWR: begin
        if (link_reset) nxt_state = trl_pkg::TRL_ST_SEARCH;
        else if (tunnel_start) nxt_state = trl_pkg::TRL_ST_TUNNEL;
      end
      trl_pkg::TRL_ST_TUNNEL: begin
        if (link_reset) nxt_state = trl_pkg::TRL_ST_SEARCH;
      end
      default: nxt_state = trl_pkg::TRL_ST_COLD;
    endcase
    // Warm restart skips OTP: shadows survive
    if (warm_fire) nxt_state = trl_pkg::TRL_ST_INIT;
    else if (!in_boot && !en_sync) nxt_state = trl_pkg::TRL_ST_IDLE;
    if (power_lost) nxt_state = trl_pkg::TRL_ST_COLD;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_ff   <= trl_pkg::TRL_ST_COLD;
      en_prev_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      en_prev_ff <= en_sync;
    end
  end

  // Boot delay counts only in cold state, saturates at the end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      boot_cnt_ff <= '0;
    end else if (state_ff != trl_pkg::TRL_ST_COLD) begin
      boot_cnt_ff <= '0;
    end else if (!boot_done && supply_good) begin
      boot_cnt_ff <= boot_cnt_ff + `TRL_CNT_W'(1);
    end
  end

  // ************************************************************
  // OTP shadow load, never cleared by warm restart
  // ************************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      otp_addr_ff <= '0;
    end else if (state_ff == trl_pkg::TRL_ST_OTP) begin
      otp_addr_ff <= otp_addr_ff + `TRL_OTP_AW'(1);
    end else begin
      otp_addr_ff <= '0;
    end
  end

  // Shadows have no reset term on purpose
  genvar gi;
  generate
    for (gi = 0; gi < `TRL_OTP_WORDS; gi++) begin : g_shadow
      always_ff @(posedge clock) begin
        if (state_ff == trl_pkg::TRL_ST_OTP &&
            otp_rd_data_idx == `TRL_OTP_AW'(gi)) begin
          shadow_word_ff[gi] <= otp_rd_data;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Configuration and pins
  // ************************************************************
  // Warm request armed until its transaction ends; set wins
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      warm_armed_ff <= 1'b0;
    end else if (warm_restart) begin
      warm_armed_ff <= 1'b1;
    end else if (cfg_xfer_done) begin
      warm_armed_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      role_ff          <= `TRL_ROLE_REMOTE;
      detect_ff        <= `TRL_DETECT_PASSIVE;
      enable_pullup_ff <= 1'b1;
      io_out_en_b_ff   <= 1'b1;
      strap_pull_ff    <= `TRL_STRAP_DEFAULT;
      ready_ff         <= 1'b0;
    end else if (in_boot) begin
      role_ff          <= `TRL_ROLE_REMOTE;
      detect_ff        <= `TRL_DETECT_PASSIVE;
      enable_pullup_ff <= 1'b1;
      io_out_en_b_ff   <= 1'b1;
      strap_pull_ff    <= `TRL_STRAP_DEFAULT;
      ready_ff         <= 1'b0;
    end else begin
      ready_ff <= 1'b1;
      if (cfg_wr) begin
        role_ff          <= cfg_role_in;
        detect_ff        <= cfg_detect_in;
        enable_pullup_ff <= cfg_pullup_in;
      end
    end
  end

  // ************************************************************
  // Link status and link-down event
  // ************************************************************
  wire enter_lowpwr = partner_search_state & (nxt_state == trl_pkg::TRL_ST_LOWPWR);
  wire link_drop    = link_reset | (en_fall & ~in_boot) | warm_fire;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      link_up_ff            <= 1'b0;
      link_down_event_ff    <= 1'b0;
      link_reset_pending_ff <= 1'b0;
    end else begin
      link_down_event_ff <= link_reset;
      if (link_drop || in_boot || nxt_state == trl_pkg::TRL_ST_IDLE) begin
        link_up_ff <= 1'b0;
      end else if (enter_lowpwr) begin
        link_up_ff <= 1'b1;
      end
      if (link_restart && !linked) begin
        link_reset_pending_ff <= 1'b1;
      end else if (pend_reset || in_boot) begin
        link_reset_pending_ff <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  chk_down_pulse: assert property (@(posedge clock) disable iff (!rst_b)
    link_reset |=> link_down_event_ff && !link_up_ff)
    else $error("link reset without link-down event");
  chk_enable_idle: assert property (@(posedge clock) disable iff (!rst_b)
    (!en_sync && !in_boot && !warm_fire && supply_good) |=> radio_idle_state)
    else $error("enable low did not force radio idle");
  chk_idle_exit: assert property (@(posedge clock) disable iff (!rst_b)
    (radio_idle_state && en_sync && !warm_fire && supply_good) |=> partner_search_state)
    else $error("radio idle not left with enable high");
  chk_linkup_rise: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(link_up_ff) |-> $past(partner_search_state))
    else $error("link-up raised outside partner search exit");
  chk_pend_hold: assert property (@(posedge clock) disable iff (!rst_b)
    (link_restart && !linked && !in_boot) |=> link_reset_pending_ff)
    else $error("early link restart not held pending");
  chk_warm_wait: assert property (@(posedge clock) disable iff (!rst_b)
    (warm_restart && !cfg_xfer_done && !power_lost) |=> !in_boot)
    else $error("warm restart before transaction end");
  chk_cold_order: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(state_ff == trl_pkg::TRL_ST_INIT) && !$past(warm_fire)
      |-> $past(state_ff == trl_pkg::TRL_ST_OTP))
    else $error("init without OTP load");
  chk_boot_defaults: assert property (@(posedge clock) disable iff (!rst_b)
    (state_ff == trl_pkg::TRL_ST_INIT) |=> (role_ff == `TRL_ROLE_REMOTE) &&
      (detect_ff == `TRL_DETECT_PASSIVE) && enable_pullup_ff && io_out_en_b_ff)
    else $error("boot defaults wrong");
  chk_config_kept: assert property (@(posedge clock) disable iff (!rst_b)
    (link_reset && !cfg_wr && !power_lost && !warm_fire) |=> $stable(role_ff))
    else $error("link reset touched configuration");
  chk_strap_legal: assert property (@(posedge clock) disable iff (!rst_b)
    strap_pull_ff != `TRL_STRAP_FORBIDDEN)
    else $error("all-ones strapping");

  cov_link_up:   cover property (@(posedge clock) disable iff (!rst_b) $rose(link_up_ff));
  cov_warm:      cover property (@(posedge clock) disable iff (!rst_b) warm_fire);
  cov_pend:      cover property (@(posedge clock) disable iff (!rst_b) pend_reset);
  cov_loss:      cover property (@(posedge clock) disable iff (!rst_b) loss_reset);

endmodule : trl_seq

// file: testbench/trl_host_model.sv
/*
  Host model for the enable pin of the reset-level sequencer.
  Assumes the bench raises en_req only after the device reports ready.
*/
`timescale 1ns/1ps
module trl_host_model #(
  parameter int HOLD_LOW = 4
) (
  input  wire logic en_req,
  output logic      radio_enable_pin
);
  // ***************************************************************
  // Host-side timing on its own 160 ns clock
  // ***************************************************************
  logic link_clk = 1'b0;
  logic pin_ff   = 1'b0;
  int   low_cnt  = 0;

  assign radio_enable_pin = pin_ff;

  always #80 link_clk = ~link_clk;

  // The pin is never raised before it has stayed low for a full doze interval
  always @(posedge link_clk) begin
    if (!en_req) begin
      pin_ff <= 1'b0;
      if (pin_ff) begin
        low_cnt <= 0;
      end else if (low_cnt < HOLD_LOW) begin
        low_cnt <= low_cnt + 1;
      end
    end else if (low_cnt >= HOLD_LOW) begin
      pin_ff <= 1'b1;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end
endmodule : trl_host_model

// file: testbench/trl_seq_tb.sv
/*
  Self-checking bench for the reset-level sequencer.
  Assumes a short boot count; the OTP is modelled as a combinational read.
*/
`timescale 1ns/1ps
`include "trl_defines.svh"
module trl_seq_tb;
  // ***************************************************************
  // Stimulus and observed signals
  // ***************************************************************
  logic                   clock = 1'b0;
  logic                   rst_b, supply_good, en_req, radio_enable_pin;
  logic                   warm_restart, cfg_xfer_done, link_restart, partner_found;
  logic                   tunnel_start, channel_lost, cfg_wr, cfg_role_in;
  logic                   cfg_detect_in, cfg_pullup_in;
  logic [`TRL_OTP_AW-1:0] otp_rd_data_idx, otp_addr_ff;
  logic [7:0]             otp_rd_data, otp_base, strap_pull_ff;
  logic                   io_out_en_b_ff, enable_pullup_ff, role_ff, detect_ff;
  logic                   link_up_ff, link_down_event_ff, link_reset_pending_ff;
  logic                   radio_idle_state, partner_search_state, ready_ff;
  logic [7:0]             shadow_word_ff [`TRL_OTP_WORDS];
  int                     bad_count, checked;

  assign otp_rd_data_idx = otp_addr_ff;
  assign otp_rd_data     = 8'(otp_base + 8'(otp_addr_ff));

  always #10 clock = ~clock;

  trl_host_model #(.HOLD_LOW(4)) i_trl_host_model (.en_req(en_req),
    .radio_enable_pin(radio_enable_pin));

  trl_seq #(.BOOT_CYCLES(8)) i_trl_seq (.clock(clock), .rst_b(rst_b),
    .supply_good(supply_good), .radio_enable_pin(radio_enable_pin),
    .warm_restart(warm_restart), .cfg_xfer_done(cfg_xfer_done),
    .link_restart(link_restart), .partner_found(partner_found),
    .tunnel_start(tunnel_start), .channel_lost(channel_lost), .cfg_wr(cfg_wr),
    .cfg_role_in(cfg_role_in), .cfg_detect_in(cfg_detect_in),
    .cfg_pullup_in(cfg_pullup_in), .otp_rd_data_idx(otp_rd_data_idx),
    .otp_rd_data(otp_rd_data), .otp_addr_ff(otp_addr_ff),
    .strap_pull_ff(strap_pull_ff), .io_out_en_b_ff(io_out_en_b_ff),
    .enable_pullup_ff(enable_pullup_ff), .role_ff(role_ff), .detect_ff(detect_ff),
    .link_up_ff(link_up_ff), .link_down_event_ff(link_down_event_ff),
    .link_reset_pending_ff(link_reset_pending_ff),
    .radio_idle_state(radio_idle_state), .partner_search_state(partner_search_state),
    .ready_ff(ready_ff), .shadow_word_ff(shadow_word_ff));

  // ***************************************************************
  // Shared helpers
  // ***************************************************************
  task give_verdict;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic pick(input int n);
    case (n)
      0: return radio_idle_state;
      1: return partner_search_state;
      2: return link_up_ff;
      3: return ready_ff;
      4: return link_down_event_ff;
      default: return role_ff;
    endcase
  endfunction : pick

  // Bounded wait; looks first in the current cycle so one-cycle events are not missed
  task await(input int n, input logic v);
    checked++;
    for (int k = 0; k < 200; k++) begin
      #1;
      if (pick(n) === v) return;
      @(posedge clock);
    end
    bad_count++;
    $display("mismatch at %0t: wait %0d timed out", $time, n);
    give_verdict;
  endtask : await

  task pulse(input int n);
    @(posedge clock);
    case (n)
      0: warm_restart  <= 1'b1;
      1: cfg_xfer_done <= 1'b1;
      2: link_restart  <= 1'b1;
      3: partner_found <= 1'b1;
      4: tunnel_start  <= 1'b1;
      5: channel_lost  <= 1'b1;
      default: cfg_wr  <= 1'b1;
    endcase
    @(posedge clock);
    {warm_restart, cfg_xfer_done, link_restart, partner_found} <= 4'h0;
    {tunnel_start, channel_lost, cfg_wr} <= 3'h0;
  endtask : pulse

  task check_shadows(input logic [7:0] base);
    for (int i = 0; i < `TRL_OTP_WORDS; i++) begin
      check(shadow_word_ff[i], 8'(base + 8'(i)));
    end
  endtask : check_shadows

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task cold_boot;
    await(3, 1'b1);
    await(0, 1'b1);
    check(strap_pull_ff, 8'hFC);
    check({6'h00, io_out_en_b_ff, enable_pullup_ff}, 8'h03);
    check({4'h0, role_ff, detect_ff, link_up_ff, radio_idle_state}, 8'h01);
    check_shadows(8'hA0);
  endtask : cold_boot

  task link_by_command;
    cfg_role_in   <= 1'b1;
    cfg_detect_in <= 1'b1;
    cfg_pullup_in <= 1'b0;
    pulse(6);
    repeat (2) @(posedge clock);
    #1;
    check({5'h00, role_ff, detect_ff, enable_pullup_ff}, 8'h06);
    en_req <= 1'b1;
    await(1, 1'b1);
    pulse(3);
    await(2, 1'b1);
    pulse(2);
    await(4, 1'b1);
    check({4'h0, link_up_ff, partner_search_state, role_ff, detect_ff}, 8'h07);
    @(posedge clock);
    #1;
    check({7'h00, link_down_event_ff}, 8'h00);
  endtask : link_by_command

  task link_by_channel;
    pulse(3);
    await(2, 1'b1);
    pulse(4);
    repeat (3) @(posedge clock);
    pulse(5);
    await(4, 1'b1);
    check({7'h00, link_up_ff}, 8'h00);
  endtask : link_by_channel

  task pending_restart;
    pulse(2);
    repeat (2) @(posedge clock);
    #1;
    check({6'h00, link_reset_pending_ff, link_down_event_ff}, 8'h02);
    pulse(3);
    await(4, 1'b1);
    check({6'h00, link_reset_pending_ff, link_up_ff}, 8'h00);
  endtask : pending_restart

  task enable_drop;
    pulse(3);
    await(2, 1'b1);
    en_req <= 1'b0;
    await(0, 1'b1);
    check({7'h00, link_up_ff}, 8'h00);
  endtask : enable_drop

  task warm_reset;
    otp_base <= 8'h50;
    pulse(0);
    repeat (3) @(posedge clock);
    #1;
    check({7'h00, role_ff}, 8'h01);
    pulse(1);
    await(5, 1'b0);
    await(0, 1'b1);
    check({6'h00, detect_ff, enable_pullup_ff}, 8'h01);
    check_shadows(8'hA0);
    // Port stays quiet for 80 us after the restart
    repeat (4000) @(posedge clock);
  endtask : warm_reset

  task power_loss;
    supply_good <= 1'b0;
    await(3, 1'b0);
    supply_good <= 1'b1;
    await(3, 1'b1);
    check_shadows(8'h50);
  endtask : power_loss

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    rst_b       = 1'b0;
    supply_good = 1'b1;
    en_req      = 1'b0;
    otp_base    = 8'hA0;
    {warm_restart, cfg_xfer_done, link_restart, partner_found} = 4'h0;
    {tunnel_start, channel_lost, cfg_wr} = 3'h0;
    {cfg_role_in, cfg_detect_in, cfg_pullup_in} = 3'h0;
    bad_count   = 0;
    checked     = 0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    cold_boot;
    link_by_command;
    link_by_channel;
    pending_restart;
    enable_drop;
    warm_reset;
    power_loss;
    give_verdict;
  end
endmodule : trl_seq_tb
